// ### verilog/bzd_pkg.sv
// Constants and helpers for the bus zone differential block
package bzd_pkg;

  localparam int N_TERM = 8;
  localparam int N_ZONE = 6;
  localparam int N_CHECK = 3;
  localparam int N_ELEM = N_ZONE + N_CHECK;
  localparam int N_PH = 3;
  localparam int SW = 16;
  localparam int AW = 20;
  localparam int TIDX_W = 3;
  localparam int ZIDX_W = 3;
  localparam int SLOPE_SHIFT = 7;
  localparam int PW = AW + 8;

  // Merged pair when the bus-tie disconnect closes
  localparam int TIE_ZONE_KEEP = 0;
  localparam int TIE_ZONE_FOLD = 1;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PICKUP = 8'h04;
  localparam logic [7:0] ADDR_SLOPE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_ZSTATE = 8'h14;
  localparam logic [7:0] ADDR_AUX = 8'h18;
  localparam logic [7:0] ADDR_HOLD = 8'h1C;
  localparam logic [7:0] ADDR_ASSIGN0 = 8'h20;
  localparam logic [7:0] ADDR_CHECK0 = 8'h40;

  // Field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_SUP = 1;
  localparam int SLOPE_SEC_LSB = 8;
  localparam int ASG_DISC_LSB = 8;
  localparam int ASG_BRK_LSB = 16;
  localparam int ZS_ACT_LSB = 8;
  localparam int ZS_CHK_LSB = 16;
  localparam int ZS_TIE = 24;
  localparam int AUX_BRK_LSB = 8;

  localparam int ST_W = 4;
  localparam int ST_ZONE_TRIP = 0;
  localparam int ST_EXT = 1;
  localparam int ST_XFER = 2;
  localparam int ST_MERGE = 3;

  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [15:0] PICKUP_RST = 16'h0100;
  localparam logic [7:0] SLOPE_NORM_RST = 8'h20;
  localparam logic [7:0] SLOPE_SEC_RST = 8'h50;
  localparam logic [15:0] HOLD_RST = 16'h0010;
  localparam logic [23:0] ASSIGN_RST = 24'h000000;
  localparam logic [7:0] CHECK_RST = 8'hFF;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ACCUM = 2'b01,
    SEQ_EVAL = 2'b11
  } seq_state_t;

  // Disconnect is open only for no=0, nc=1
  function automatic logic disc_closed(input logic no, input logic nc);
    disc_closed = no | ~nc;
  endfunction : disc_closed

  function automatic logic [SW-1:0] mag_s(input logic signed [SW-1:0] v);
    mag_s = v[SW-1] ? SW'(-v) : SW'(v);
  endfunction : mag_s

  function automatic logic [AW-1:0] mag_a(input logic signed [AW-1:0] v);
    mag_a = v[AW-1] ? AW'(-v) : AW'(v);
  endfunction : mag_a

  function automatic int check_of_zone(input int z);
    check_of_zone = z / 2;
  endfunction : check_of_zone

endpackage : bzd_pkg

// ### verilog/bzd_diff_element.sv
// One phase of an adaptive percentage differential element with external fault detection
`timescale 1ns/1ps
module bzd_diff_element (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_eval,
  input wire logic [bzd_pkg::AW-1:0] i_operate,
  input wire logic [bzd_pkg::AW-1:0] i_restraint,
  input wire logic [15:0] i_pickup,
  input wire logic [7:0] i_slope_norm,
  input wire logic [7:0] i_slope_sec,
  input wire logic [15:0] i_hs_hold,
  output logic o_trip,
  output logic o_ext_fault,
  output logic o_high_security
);

  logic [bzd_pkg::AW-1:0] prev_op;
  logic [bzd_pkg::AW-1:0] prev_rt;
  logic [15:0] hs_cnt;
  logic [bzd_pkg::AW-1:0] op_rise;
  logic [bzd_pkg::AW-1:0] rt_rise;
  logic [bzd_pkg::AW-1:0] pickup_w;
  logic ext_now;
  logic secure;
  logic [7:0] slope;
  logic [bzd_pkg::PW-1:0] op_scaled;
  logic [bzd_pkg::PW-1:0] rt_scaled;
  logic next_trip;

  always_comb begin
    pickup_w = bzd_pkg::AW'(i_pickup);
    op_rise = (i_operate > prev_op) ? i_operate - prev_op : '0;
    rt_rise = (i_restraint > prev_rt) ? i_restraint - prev_rt : '0;
    // Saturated CTs show restraint rising well ahead of operate
    ext_now = (rt_rise > pickup_w) && ({op_rise, 1'b0} < {1'b0, rt_rise}) && !o_trip;
    secure = ext_now || (hs_cnt != '0);
    slope = secure ? i_slope_sec : i_slope_norm;
    op_scaled = bzd_pkg::PW'(i_operate) << bzd_pkg::SLOPE_SHIFT;
    rt_scaled = bzd_pkg::PW'(i_restraint) * bzd_pkg::PW'(slope);
    next_trip = (i_operate > pickup_w) && (op_scaled > rt_scaled);
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prev_op <= '0;
      prev_rt <= '0;
      hs_cnt <= '0;
      o_trip <= 1'b0;
      o_ext_fault <= 1'b0;
      o_high_security <= 1'b0;
    end else if (i_eval) begin
      prev_op <= i_operate;
      prev_rt <= i_restraint;
      // Hold the steep slope for a while after detection
      if (ext_now) begin
        hs_cnt <= i_hs_hold;
      end else if (hs_cnt != '0) begin
        hs_cnt <= hs_cnt - 16'h0001;
      end
      o_trip <= next_trip;
      o_ext_fault <= ext_now;
      o_high_security <= secure;
    end
  end

endmodule : bzd_diff_element

// ### verilog/bus_zone_differential_select.sv
// Bus zone differential: zone selection, six zones, three check zones, APB registers
// Functional notes
// - Six independent differential elements, each from its own assigned terminal currents.
// - Internal fault trips well within one power cycle.
// - External fault flagged from restraint versus operate rate of change, under 2 ms.
// - After an external fault the element switches to the steeper slope.
// - First evaluate assignment conditions, then route currents to the zone elements.
// - A true condition includes the terminal current in its zone.
// - A false condition excludes the terminal current from its zone.
// - Zone trips reach only terminals whose condition is true.
// - A closed bus-tie disconnect merges the two tied zones into one.
// - Breaker aux in the condition drops an open feeder from the zone.
// - Fault between open breaker and CT raises a transfer trip to remote end.
// - Three independent check zones, each with its own adaptive element.
// - Check zones watch all chosen terminals per phase and supervise zone trips.
// - Check zone output asserts for an internal bus fault.
// - Check zone output stays low for an external fault.
// - On report request, list terminals and bus-zones of each active zone.
// - Disconnect reads open only for normally-open 0 and normally-closed 1.
`timescale 1ns/1ps
module bus_zone_differential_select (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_sample_valid,
  input wire logic [bzd_pkg::N_TERM*bzd_pkg::N_PH*bzd_pkg::SW-1:0] i_sample,
  input wire logic [bzd_pkg::N_TERM-1:0] i_disconnect_aux_normally_open,
  input wire logic [bzd_pkg::N_TERM-1:0] i_disconnect_aux_normally_closed,
  input wire logic i_bus_tie_disconnect_normally_open,
  input wire logic i_bus_tie_disconnect_normally_closed,
  input wire logic [bzd_pkg::N_TERM-1:0] i_breaker_aux_closed,
  input wire logic i_report_req,
  output logic [bzd_pkg::N_TERM-1:0] o_term_trip,
  output logic [bzd_pkg::N_TERM-1:0] o_transfer_trip,
  output logic [bzd_pkg::N_ZONE-1:0] o_zone_trip,
  output logic [bzd_pkg::N_ZONE-1:0] o_ext_fault,
  output logic [bzd_pkg::N_CHECK-1:0] o_check_operate,
  output logic o_irq,
  output logic o_report_valid,
  output logic [bzd_pkg::ZIDX_W-1:0] o_report_zone,
  output logic [bzd_pkg::N_TERM-1:0] o_report_terms,
  output logic [bzd_pkg::N_ZONE-1:0] o_report_buses,
  output logic o_report_done
);

  localparam int NT = bzd_pkg::N_TERM;
  localparam int NZ = bzd_pkg::N_ZONE;
  localparam int NE = bzd_pkg::N_ELEM;
  localparam int NP = bzd_pkg::N_PH;
  localparam int AW = bzd_pkg::AW;
  localparam int SW = bzd_pkg::SW;
  localparam int XW = 3 * NT + 2;

  // Configuration and status registers
  logic [1:0] ctrl;
  logic [15:0] pickup;
  logic [7:0] slope_norm;
  logic [7:0] slope_sec;
  logic [15:0] hs_hold;
  logic [23:0] assign_cfg [NZ];
  logic [NT-1:0] check_cfg [bzd_pkg::N_CHECK];
  logic [bzd_pkg::ST_W-1:0] status;
  logic [bzd_pkg::ST_W-1:0] mask;

  // Pin synchroniser: three stages, accepted once stages two and three agree
  logic [XW-1:0] aux_s1;
  logic [XW-1:0] aux_s2;
  logic [XW-1:0] aux_s3;
  logic [XW-1:0] aux_stable;

  logic [NT-1:0] disc_cl;
  logic [NT-1:0] brk_cl;
  logic tie_closed;
  logic [NT-1:0] cond [NZ];
  logic [NT-1:0] eff [NZ];
  logic [NZ-1:0] bus_map [NZ];

  bzd_pkg::seq_state_t state;
  logic [bzd_pkg::TIDX_W-1:0] idx;
  logic [NT*NP*SW-1:0] samp_q;
  logic [NT-1:0] memb [NE];
  logic [NT-1:0] asg_snap [NZ];
  logic [NZ-1:0] bus_snap [NZ];
  logic tie_snap;
  logic signed [AW-1:0] acc_op [NE][NP];
  logic [AW-1:0] acc_rt [NE][NP];
  logic [AW-1:0] op_q [NE][NP];
  logic [AW-1:0] rt_q [NE][NP];
  logic eval_pulse;
  logic [NT-1:0] xfer_flag;

  logic el_trip [NE][NP];
  logic el_ext [NE][NP];
  logic [NE-1:0] elem_trip;
  logic [NE-1:0] elem_ext;
  logic [NZ-1:0] next_zone_trip;
  logic [NT-1:0] next_term_trip;
  logic [bzd_pkg::ST_W-1:0] events;
  logic [bzd_pkg::ST_W-1:0] next_status;
  logic tie_prev;

  logic rep_busy;
  logic [bzd_pkg::ZIDX_W-1:0] rep_z;

  logic apb_wr;
  logic [31:0] rd_val;
  logic rd_hit;

  function automatic logic signed [SW-1:0] term_sample(
    input logic [NT*NP*SW-1:0] s, input logic [bzd_pkg::TIDX_W-1:0] t, input int p);
    term_sample = s[(int'(t) * NP + p) * SW +: SW];
  endfunction : term_sample

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aux_s1 <= '0;
      aux_s2 <= '0;
      aux_s3 <= '0;
      aux_stable <= '0;
    end else begin
      aux_s1 <= {i_breaker_aux_closed, i_bus_tie_disconnect_normally_closed,
                 i_bus_tie_disconnect_normally_open, i_disconnect_aux_normally_closed,
                 i_disconnect_aux_normally_open};
      aux_s2 <= aux_s1;
      aux_s3 <= aux_s2;
      aux_stable <= (~(aux_s2 ^ aux_s3) & aux_s3) | ((aux_s2 ^ aux_s3) & aux_stable);
    end
  end

  // Step one: evaluate every terminal condition
  always_comb begin
    for (int t = 0; t < NT; t++) begin
      disc_cl[t] = bzd_pkg::disc_closed(aux_stable[t], aux_stable[NT + t]);
    end
    tie_closed = bzd_pkg::disc_closed(aux_stable[2 * NT], aux_stable[2 * NT + 1]);
    brk_cl = aux_stable[2 * NT + 2 +: NT];
    for (int z = 0; z < NZ; z++) begin
      // An open breaker that is required makes the condition false
      cond[z] = assign_cfg[z][NT-1:0]
              & (~assign_cfg[z][bzd_pkg::ASG_DISC_LSB +: NT] | disc_cl)
              & (~assign_cfg[z][bzd_pkg::ASG_BRK_LSB +: NT] | brk_cl);
      eff[z] = cond[z];
      bus_map[z] = NZ'(1) << z;
    end
    if (tie_closed) begin
      // Fold the second zone into the first, both terminals and bus-zones
      eff[bzd_pkg::TIE_ZONE_KEEP] = cond[bzd_pkg::TIE_ZONE_KEEP] | cond[bzd_pkg::TIE_ZONE_FOLD];
      eff[bzd_pkg::TIE_ZONE_FOLD] = '0;
      bus_map[bzd_pkg::TIE_ZONE_KEEP] = bus_map[bzd_pkg::TIE_ZONE_KEEP]
                                      | bus_map[bzd_pkg::TIE_ZONE_FOLD];
      bus_map[bzd_pkg::TIE_ZONE_FOLD] = '0;
    end
    for (int e = 0; e < NE; e++) begin
      memb[e] = (e < NZ) ? asg_snap[e] : check_cfg[e - NZ];
    end
  end

  // Sequencer: snapshot at the interval strobe, accumulate, evaluate
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= bzd_pkg::SEQ_IDLE;
      idx <= '0;
      eval_pulse <= 1'b0;
    end else begin
      eval_pulse <= 1'b0;
      case (state)
        bzd_pkg::SEQ_IDLE: begin
          if (i_sample_valid && ctrl[bzd_pkg::CTRL_EN]) begin
            state <= bzd_pkg::SEQ_ACCUM;
            idx <= '0;
          end
        end
        bzd_pkg::SEQ_ACCUM: begin
          idx <= idx + 1'b1;
          if (idx == bzd_pkg::TIDX_W'(NT - 1)) begin
            state <= bzd_pkg::SEQ_EVAL;
          end
        end
        bzd_pkg::SEQ_EVAL: begin
          eval_pulse <= 1'b1;
          state <= bzd_pkg::SEQ_IDLE;
        end
        default: begin
          state <= bzd_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // New conditions are caught at the first interval strobe after the pin synchroniser has accepted them
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      samp_q <= '0;
      tie_snap <= 1'b0;
      for (int z = 0; z < NZ; z++) begin
        asg_snap[z] <= '0;
        bus_snap[z] <= '0;
      end
    end else if (state == bzd_pkg::SEQ_IDLE && i_sample_valid && ctrl[bzd_pkg::CTRL_EN]) begin
      samp_q <= i_sample;
      tie_snap <= tie_closed;
      for (int z = 0; z < NZ; z++) begin
        asg_snap[z] <= eff[z];
        bus_snap[z] <= bus_map[z];
      end
    end
  end

  // Step two: route each terminal into the sums of its zones
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int e = 0; e < NE; e++) begin
        for (int p = 0; p < NP; p++) begin
          acc_op[e][p] <= '0;
          acc_rt[e][p] <= '0;
          op_q[e][p] <= '0;
          rt_q[e][p] <= '0;
        end
      end
      xfer_flag <= '0;
    end else if (state == bzd_pkg::SEQ_IDLE) begin
      for (int e = 0; e < NE; e++) begin
        for (int p = 0; p < NP; p++) begin
          acc_op[e][p] <= '0;
          acc_rt[e][p] <= '0;
        end
      end
    end else if (state == bzd_pkg::SEQ_ACCUM) begin
      for (int e = 0; e < NE; e++) begin
        for (int p = 0; p < NP; p++) begin
          if (memb[e][idx]) begin
            // Signed sum for operate, magnitude sum for restraint
            acc_op[e][p] <= acc_op[e][p] + AW'(term_sample(samp_q, idx, p));
            acc_rt[e][p] <= acc_rt[e][p] + AW'(bzd_pkg::mag_s(term_sample(samp_q, idx, p)));
          end
        end
      end
      // Current still flowing past an open breaker means a dead-zone fault
      xfer_flag[idx] <= 1'b0;
      for (int p = 0; p < NP; p++) begin
        if (!brk_cl[idx] && disc_cl[idx]
            && bzd_pkg::mag_s(term_sample(samp_q, idx, p)) > pickup) begin
          xfer_flag[idx] <= 1'b1;
        end
      end
    end else begin
      for (int e = 0; e < NE; e++) begin
        for (int p = 0; p < NP; p++) begin
          op_q[e][p] <= bzd_pkg::mag_a(acc_op[e][p]);
          rt_q[e][p] <= acc_rt[e][p];
        end
      end
    end
  end

  // Six zone elements then three check elements, each per phase
  for (genvar e = 0; e < NE; e++) begin : g_elem
    for (genvar p = 0; p < NP; p++) begin : g_ph
      bzd_diff_element u_elem (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_eval(eval_pulse),
        .i_operate(op_q[e][p]),
        .i_restraint(rt_q[e][p]),
        .i_pickup(pickup),
        .i_slope_norm(slope_norm),
        .i_slope_sec(slope_sec),
        .i_hs_hold(hs_hold),
        .o_trip(el_trip[e][p]),
        .o_ext_fault(el_ext[e][p]),
        .o_high_security()
      );
    end
  end

  always_comb begin
    for (int e = 0; e < NE; e++) begin
      elem_trip[e] = 1'b0;
      elem_ext[e] = 1'b0;
      for (int p = 0; p < NP; p++) begin
        elem_trip[e] = elem_trip[e] | el_trip[e][p];
        elem_ext[e] = elem_ext[e] | el_ext[e][p];
      end
    end
    next_term_trip = '0;
    for (int z = 0; z < NZ; z++) begin
      // Check zone supervises its zones when enabled
      next_zone_trip[z] = elem_trip[z] & (~ctrl[bzd_pkg::CTRL_SUP]
                        | elem_trip[NZ + bzd_pkg::check_of_zone(z)]);
      // Trip only terminals assigned in this interval
      next_term_trip = next_term_trip | ({NT{next_zone_trip[z]}} & asg_snap[z]);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_zone_trip <= '0;
      o_term_trip <= '0;
      o_ext_fault <= '0;
      o_check_operate <= '0;
      o_transfer_trip <= '0;
    end else begin
      o_zone_trip <= next_zone_trip;
      o_term_trip <= next_term_trip;
      o_ext_fault <= elem_ext[NZ-1:0];
      o_check_operate <= elem_trip[NE-1:NZ];
      if (eval_pulse) begin
        o_transfer_trip <= xfer_flag;
      end
    end
  end

  // Zone report: one beat per zone with bus-zones in the snapshot, done strobe in the same cycle as the last zone's slot
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rep_busy <= 1'b0;
      rep_z <= '0;
      o_report_valid <= 1'b0;
      o_report_zone <= '0;
      o_report_terms <= '0;
      o_report_buses <= '0;
      o_report_done <= 1'b0;
    end else begin
      o_report_valid <= 1'b0;
      o_report_done <= 1'b0;
      if (!rep_busy) begin
        if (i_report_req) begin
          rep_busy <= 1'b1;
          rep_z <= '0;
        end
      end else begin
        if (bus_snap[rep_z] != '0) begin
          o_report_valid <= 1'b1;
          o_report_zone <= rep_z;
          o_report_terms <= asg_snap[rep_z];
          o_report_buses <= bus_snap[rep_z];
        end
        if (rep_z == bzd_pkg::ZIDX_W'(NZ - 1)) begin
          rep_busy <= 1'b0;
          o_report_done <= 1'b1;
        end else begin
          rep_z <= rep_z + 1'b1;
        end
      end
    end
  end

  // Sticky events; a set in the clearing cycle wins
  always_comb begin
    events = '0;
    events[bzd_pkg::ST_ZONE_TRIP] = |(next_zone_trip & ~o_zone_trip);
    events[bzd_pkg::ST_EXT] = |(elem_ext[NZ-1:0] & ~o_ext_fault);
    events[bzd_pkg::ST_XFER] = eval_pulse & |(xfer_flag & ~o_transfer_trip);
    events[bzd_pkg::ST_MERGE] = tie_snap ^ tie_prev;
    next_status = status;
    if (apb_wr && i_paddr == bzd_pkg::ADDR_STATUS) begin
      next_status = status & ~i_pwdata[bzd_pkg::ST_W-1:0];
    end
    next_status = next_status | events;
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status <= '0;
      tie_prev <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      status <= next_status;
      tie_prev <= tie_snap;
      o_irq <= |(next_status & mask);
    end
  end

  // APB slave: one wait-free access phase; unmapped reads 0 with slave error
  assign apb_wr = i_psel && i_penable && o_pready && i_pwrite;

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (i_paddr)
      bzd_pkg::ADDR_CTRL: rd_val = 32'(ctrl);
      bzd_pkg::ADDR_PICKUP: rd_val = 32'(pickup);
      bzd_pkg::ADDR_SLOPE: rd_val = 32'({slope_sec, slope_norm});
      bzd_pkg::ADDR_STATUS: rd_val = 32'(status);
      bzd_pkg::ADDR_MASK: rd_val = 32'(mask);
      bzd_pkg::ADDR_ZSTATE: begin
        rd_val[NZ-1:0] = o_zone_trip;
        for (int z = 0; z < NZ; z++) begin
          rd_val[bzd_pkg::ZS_ACT_LSB + z] = |asg_snap[z];
        end
        rd_val[bzd_pkg::ZS_CHK_LSB +: bzd_pkg::N_CHECK] = o_check_operate;
        rd_val[bzd_pkg::ZS_TIE] = tie_snap;
      end
      bzd_pkg::ADDR_AUX: rd_val = 32'({brk_cl, disc_cl});
      bzd_pkg::ADDR_HOLD: rd_val = 32'(hs_hold);
      default: begin
        rd_hit = 1'b0;
        for (int z = 0; z < NZ; z++) begin
          if (i_paddr == bzd_pkg::ADDR_ASSIGN0 + 8'(4 * z)) begin
            rd_val = 32'(assign_cfg[z]);
            rd_hit = 1'b1;
          end
        end
        for (int k = 0; k < bzd_pkg::N_CHECK; k++) begin
          if (i_paddr == bzd_pkg::ADDR_CHECK0 + 8'(4 * k)) begin
            rd_val = 32'(check_cfg[k]);
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable && !o_pready;
      if (i_psel && !i_penable) begin
        o_prdata <= i_pwrite ? '0 : rd_val;
        o_pslverr <= !rd_hit || (i_pwrite && i_paddr == bzd_pkg::ADDR_ZSTATE);
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl <= bzd_pkg::CTRL_RST;
      pickup <= bzd_pkg::PICKUP_RST;
      slope_norm <= bzd_pkg::SLOPE_NORM_RST;
      slope_sec <= bzd_pkg::SLOPE_SEC_RST;
      hs_hold <= bzd_pkg::HOLD_RST;
      mask <= '0;
      for (int z = 0; z < NZ; z++) begin
        assign_cfg[z] <= bzd_pkg::ASSIGN_RST;
      end
      for (int k = 0; k < bzd_pkg::N_CHECK; k++) begin
        check_cfg[k] <= bzd_pkg::CHECK_RST;
      end
    end else if (apb_wr) begin
      case (i_paddr)
        bzd_pkg::ADDR_CTRL: ctrl <= i_pwdata[1:0];
        bzd_pkg::ADDR_PICKUP: pickup <= i_pwdata[15:0];
        bzd_pkg::ADDR_SLOPE: begin
          slope_norm <= i_pwdata[7:0];
          slope_sec <= i_pwdata[bzd_pkg::SLOPE_SEC_LSB +: 8];
        end
        bzd_pkg::ADDR_MASK: mask <= i_pwdata[bzd_pkg::ST_W-1:0];
        bzd_pkg::ADDR_HOLD: hs_hold <= i_pwdata[15:0];
        default: begin
          for (int z = 0; z < NZ; z++) begin
            if (i_paddr == bzd_pkg::ADDR_ASSIGN0 + 8'(4 * z)) begin
              assign_cfg[z] <= i_pwdata[23:0];
            end
          end
          for (int k = 0; k < bzd_pkg::N_CHECK; k++) begin
            if (i_paddr == bzd_pkg::ADDR_CHECK0 + 8'(4 * k)) begin
              check_cfg[k] <= i_pwdata[NT-1:0];
            end
          end
        end
      endcase
    end
  end

endmodule : bus_zone_differential_select

// ### tb/bzd_chk.sv
// Port timing checks for the bus zone differential block
`timescale 1ns/1ps
module bzd_chk (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic i_sample_valid,
  input wire logic i_report_req,
  input wire logic o_report_valid,
  input wire logic o_report_done,
  input wire logic [bzd_pkg::N_TERM-1:0] o_term_trip,
  input wire logic [bzd_pkg::N_TERM-1:0] o_transfer_trip,
  input wire logic [bzd_pkg::N_ZONE-1:0] o_zone_trip,
  input wire logic [bzd_pkg::N_ZONE-1:0] o_ext_fault,
  input wire logic [bzd_pkg::N_CHECK-1:0] o_check_operate
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_apb_answer: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_ready_once: assert property (o_pready |=> !o_pready)
    else $error("ready too long");
  a_zone_time: assert property ($changed(o_zone_trip) |-> $past(i_sample_valid, 12))
    else $error("zone trip off slot");
  a_ext_time: assert property ($changed(o_ext_fault) |-> $past(i_sample_valid, 12))
    else $error("ext flag off slot");
  a_check_time: assert property ($changed(o_check_operate) |-> $past(i_sample_valid, 12))
    else $error("check off slot");
  a_xfer_time: assert property ($changed(o_transfer_trip) |-> $past(i_sample_valid, 11))
    else $error("xfer off slot");
  a_term_gate: assert property ((|o_term_trip) |-> (|o_zone_trip))
    else $error("terminal trip without zone trip");
  a_report_end: assert property (o_report_done |-> $past(i_report_req, 7))
    else $error("late report end");
  a_report_run: assert property (o_report_valid |-> ##[0:5] o_report_done)
    else $error("report too long");
endmodule : bzd_chk
bind bus_zone_differential_select bzd_chk bzd_chk_inst (.*);

// ### tb/bzd_field.sv
// Field side: CT samples and disconnect, tie and breaker contacts
`timescale 1ns/1ps
module bzd_field (
  input wire logic i_clk_sys,
  input wire logic i_go,
  input wire logic [2:0][15:0] i_cur,
  input wire logic [7:0] i_open,
  input wire logic [7:0] i_brk_open,
  input wire logic i_tie,
  output logic o_sample_valid,
  output logic [383:0] o_sample,
  output logic [7:0] o_no,
  output logic [7:0] o_nc,
  output logic o_tie_no,
  output logic o_tie_nc,
  output logic [7:0] o_brk
);
  always @(posedge i_clk_sys) o_sample_valid <= i_go;
  // All three phases carry the same current; unused terminals are dead
  assign o_sample = {240'h0, {3{i_cur[2]}}, {3{i_cur[1]}}, {3{i_cur[0]}}};
  assign o_no = ~i_open;
  assign o_nc = i_open;
  assign o_tie_no = i_tie;
  assign o_tie_nc = ~i_tie;
  assign o_brk = ~i_brk_open;
endmodule : bzd_field

// ### tb/tb.sv
// Self-checking bench for the bus zone differential block
`timescale 1ns/1ps
module tb;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic i_report_req = 1'b0, go = 1'b0, tie = 1'b0;
  logic [7:0] i_paddr = 8'h00, dopen = 8'h00, bopen = 8'h00;
  logic [31:0] i_pwdata = 32'h00000000;
  logic [2:0][15:0] cur = '0;
  logic i_sample_valid, i_bus_tie_disconnect_normally_open, i_bus_tie_disconnect_normally_closed;
  logic [383:0] i_sample;
  logic [7:0] i_disconnect_aux_normally_open, i_disconnect_aux_normally_closed;
  logic [7:0] i_breaker_aux_closed, o_term_trip, o_transfer_trip, o_report_terms;
  logic [31:0] o_prdata, rd;
  logic o_pready, o_pslverr, o_irq, o_report_valid, o_report_done;
  logic [5:0] o_zone_trip, o_ext_fault, o_report_buses;
  logic [2:0] o_check_operate, o_report_zone;
  int error_cnt = 0, checked = 0, cyc = 0;
  bus_zone_differential_select bus_zone_differential_select_inst (.*);
  bzd_field bzd_field_inst (.i_clk_sys(i_clk_sys), .i_go(go), .i_cur(cur), .i_open(dopen),
    .i_brk_open(bopen), .i_tie(tie), .o_sample_valid(i_sample_valid), .o_sample(i_sample),
    .o_no(i_disconnect_aux_normally_open), .o_nc(i_disconnect_aux_normally_closed),
    .o_tie_no(i_bus_tie_disconnect_normally_open),
    .o_tie_nc(i_bus_tie_disconnect_normally_closed), .o_brk(i_breaker_aux_closed));
  always #25 i_clk_sys = ~i_clk_sys;
  task automatic test_done;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do @(posedge i_clk_sys); while (o_pready !== 1'b1);
    rd = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  // Contacts settle first, then the evaluation latency passes
  task automatic strobe;
    repeat (5) @(posedge i_clk_sys);
    go <= 1'b1;
    @(posedge i_clk_sys);
    go <= 1'b0;
    repeat (14) @(posedge i_clk_sys);
  endtask : strobe
  task automatic t_regs;
    apb(1'b0, bzd_pkg::ADDR_SLOPE, 0);
    chk("slope", rd, {bzd_pkg::SLOPE_SEC_RST, bzd_pkg::SLOPE_NORM_RST});
    apb(1'b0, 8'hFC, 0);
    chk("unmapped", {rd[30:0], o_pslverr}, 32'h00000001);
  endtask : t_regs
  task automatic t_internal;
    apb(1'b1, bzd_pkg::ADDR_ASSIGN0, 32'h00000303);
    cur <= {16'h0000, 16'h0800, 16'h0800};
    strobe();
    chk("zone", o_zone_trip, 6'h01);
    chk("term", o_term_trip, 8'h03);
    chk("check", o_check_operate, 3'h7);
    chk("irq masked", o_irq, 1'b0);
    apb(1'b1, bzd_pkg::ADDR_MASK, 32'h00000001);
    repeat (2) @(posedge i_clk_sys);
    chk("irq", o_irq, 1'b1);
    apb(1'b1, bzd_pkg::ADDR_STATUS, 32'h00000001);
    repeat (2) @(posedge i_clk_sys);
    chk("irq clear", o_irq, 1'b0);
  endtask : t_internal
  task automatic t_open;
    dopen <= 8'h02;
    strobe();
    chk("term open", o_term_trip, 8'h01);
    apb(1'b0, bzd_pkg::ADDR_AUX, 0);
    chk("aux", rd[7:0], 8'hFD);
  endtask : t_open
  task automatic t_external;
    dopen <= 8'h00;
    cur <= '0;
    strobe();
    cur <= {16'h0000, 16'hF800, 16'h0800};
    strobe();
    chk("ext", o_ext_fault, 6'h01);
    chk("ext zone", o_zone_trip, 6'h00);
    chk("ext check", o_check_operate, 3'h0);
    cur <= {16'h0000, 16'hFC00, 16'h0800};
    strobe();
    chk("secure", o_zone_trip, 6'h00);
  endtask : t_external
  task automatic t_dead_zone;
    apb(1'b1, bzd_pkg::ADDR_ASSIGN0, 32'h00020303);
    bopen <= 8'h02;
    strobe();
    chk("dead term", o_term_trip[1], 1'b0);
    chk("xfer", o_transfer_trip, 8'h02);
  endtask : t_dead_zone
  task automatic t_tie_report;
    apb(1'b1, bzd_pkg::ADDR_ASSIGN0 + 8'h04, 32'h00000404);
    bopen <= 8'h00;
    tie <= 1'b1;
    cur <= '0;
    strobe();
    i_report_req <= 1'b1;
    @(posedge i_clk_sys);
    i_report_req <= 1'b0;
    do @(posedge i_clk_sys); while (o_report_valid !== 1'b1);
    chk("rzone", o_report_zone, 3'h0);
    chk("rbus", o_report_buses, 6'h03);
    chk("rterm", o_report_terms, 8'h07);
  endtask : t_tie_report
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    t_regs();
    t_internal();
    t_open();
    t_external();
    t_dead_zone();
    t_tie_report();
    test_done();
  end
endmodule : tb
